// file: core/mjc_join_ctrl.sv
// network formation and joining controller for one mesh radio node
`default_nettype none

module mjc_join_ctrl
  import mjc_pkg::*;
#(
  parameter int SECOND_CNT = SECOND_CYCLES,
  parameter int HALF_SECOND_CNT = HALF_SECOND_CYCLES,
  parameter int BLINK_UNIT_CNT = BLINK_UNIT_CYCLES
) (
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // settings from the host
  input wire mjc_cfg_t cfg_in,
  input wire logic net_reset_in,
  // retained parameters
  input wire logic nv_valid_in,
  input wire logic [7:0] nv_channel_in,
  input wire logic [15:0] nv_pan_in,
  output logic nv_write_out,
  // radio scan
  output logic scan_req_out,
  output logic scan_energy_mode_out,
  output logic [7:0] scan_channel_out,
  output logic [3:0] scan_dwell_out,
  input wire logic scan_done_in,
  input wire mjc_scan_t scan_in,
  // association and discovery
  output logic assoc_req_out,
  input wire logic assoc_done_in,
  input wire logic assoc_ok_in,
  input wire logic [15:0] assoc_addr_in,
  output logic disc_req_out,
  input wire logic disc_done_in,
  input wire logic [63:0] disc_addr_in,
  // child admission
  input wire logic child_req_in,
  output logic child_accept_out,
  output logic child_refuse_out,
  output logic [3:0] child_count_out,
  output logic permit_open_out,
  // host status
  output logic modem_status_valid_out,
  output logic [7:0] modem_status_code_out,
  output logic [7:0] join_status_code_out,
  output logic [7:0] operating_channel_out,
  output logic [15:0] operating_identifier_out,
  output logic [15:0] own_short_address_out,
  output logic [63:0] coord_long_address_out,
  output logic [127:0] active_key_out,
  output logic online_out,
  // association indicator pin
  output logic assoc_pin_out,
  output logic assoc_pin_oe_out
);

  logic rst_meta_q;
  logic rst_sync_q;
  mjc_regs_t s_q;
  mjc_regs_t s_d;
  logic is_coord;
  logic is_end;
  logic online;
  logic id_any;
  logic key_ok;
  logic pan_ok;
  logic [31:0] led_limit;

  // reset release through two flops
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign is_coord = (cfg_in.role == ROLE_COORD);
  assign is_end = (cfg_in.role == ROLE_END);
  assign online = (s_q.state == ST_ONLINE);
  assign id_any = (cfg_in.network_identifier_setting == ANY_IDENTIFIER);
  // key either held already or deliverable over the air
  assign key_ok = !cfg_in.security_enable || !scan_in.beacon_key_needed
                  || (cfg_in.encryption_options != 8'h00);
  assign pan_ok = id_any || (scan_in.beacon_pan == cfg_in.network_identifier_setting);

  always_comb begin
    if (cfg_in.blink_time_setting != 8'h00) begin
      led_limit = 32'(cfg_in.blink_time_setting) * 32'(BLINK_UNIT_CNT);
    end else if (is_coord) begin
      led_limit = 32'(SECOND_CNT);
    end else begin
      led_limit = 32'(HALF_SECOND_CNT);
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.scan_req = 1'b0;
    s_d.assoc_req = 1'b0;
    s_d.disc_req = 1'b0;
    s_d.ms_valid = 1'b0;
    s_d.nv_write = 1'b0;
    s_d.child_accept = 1'b0;
    s_d.child_refuse = 1'b0;
    s_d.dwell = cfg_in.scan_duration_setting;
    s_d.pin_oe = cfg_in.indicator_pin_function;
    s_d.lfsr = {s_q.lfsr[14:0], s_q.lfsr[15] ^ s_q.lfsr[13] ^ s_q.lfsr[12] ^ s_q.lfsr[10]};

    case (s_q.state)
      ST_IDLE: begin
        if (nv_valid_in) begin
          // retained parameters bring the node straight back online
          s_d.chan = nv_channel_in;
          s_d.pan = nv_pan_in;
          s_d.short_addr = is_coord ? 16'h0000 : s_q.short_addr;
          s_d.key = cfg_in.network_key_setting;
          s_d.status = JS_OK;
          s_d.state = ST_ONLINE;
        end else if (is_coord) begin
          s_d.idx = 4'h0;
          s_d.waiting = 1'b0;
          s_d.best_energy = 8'hFF;
          s_d.best_idx = 4'h0;
          s_d.state = ST_ENERGY;
        end else begin
          s_d.idx = 4'h0;
          s_d.waiting = 1'b0;
          s_d.any_net = 1'b0;
          s_d.status = JS_SCANNING;
          s_d.state = ST_JOINSCAN;
        end
      end

      ST_ENERGY: begin
        if (!s_q.waiting) begin
          if (cfg_in.scan_channel_mask[s_q.idx]) begin
            s_d.scan_req = 1'b1;
            s_d.scan_energy_mode = 1'b1;
            s_d.chan = FIRST_CHANNEL + 8'(s_q.idx);
            s_d.waiting = 1'b1;
          end else if (s_q.idx == 4'hF) begin
            s_d.chan = FIRST_CHANNEL + 8'(s_q.best_idx);
            s_d.pan = id_any ? s_q.lfsr : cfg_in.network_identifier_setting;
            s_d.state = ST_NETSCAN;
          end else begin
            s_d.idx = s_q.idx + 4'h1;
          end
        end else if (scan_done_in) begin
          s_d.waiting = 1'b0;
          if (scan_in.energy <= s_q.best_energy) begin
            s_d.best_energy = scan_in.energy;
            s_d.best_idx = s_q.idx;
          end
          if (s_q.idx == 4'hF) begin
            s_d.chan = FIRST_CHANNEL + 8'((scan_in.energy <= s_q.best_energy) ? s_q.idx : s_q.best_idx);
            s_d.pan = id_any ? s_q.lfsr : cfg_in.network_identifier_setting;
            s_d.state = ST_NETSCAN;
          end else begin
            s_d.idx = s_q.idx + 4'h1;
          end
        end
      end

      ST_NETSCAN: begin
        if (!s_q.waiting) begin
          s_d.scan_req = 1'b1;
          s_d.scan_energy_mode = 1'b0;
          s_d.waiting = 1'b1;
        end else if (scan_done_in) begin
          s_d.waiting = 1'b0;
          if (scan_in.beacon_seen && id_any
              && (scan_in.beacon_pan == s_q.pan || s_q.pan == ANY_IDENTIFIER)) begin
            // identifier clash on the chosen channel: draw again
            s_d.pan = s_q.lfsr;
          end else if (s_q.pan == ANY_IDENTIFIER) begin
            s_d.pan = s_q.lfsr;
          end else begin
            s_d.short_addr = 16'h0000;
            s_d.key = cfg_in.security_enable ? cfg_in.network_key_setting : 128'h0;
            s_d.status = JS_OK;
            s_d.nv_write = 1'b1;
            s_d.ms_valid = cfg_in.frame_mode_enable;
            s_d.ms_code = MS_COORD_STARTED;
            s_d.state = ST_ONLINE;
          end
        end
      end

      ST_JOINSCAN: begin
        if (!s_q.waiting) begin
          if (cfg_in.scan_channel_mask[s_q.idx]) begin
            s_d.scan_req = 1'b1;
            s_d.scan_energy_mode = 1'b0;
            s_d.chan = FIRST_CHANNEL + 8'(s_q.idx);
            s_d.waiting = 1'b1;
          end else begin
            s_d.idx = s_q.idx + 4'h1;
            if (s_q.idx == 4'hF) begin
              // a pass also ends on a masked-off last channel
              s_d.status = s_q.any_net ? JS_WRONG_ID : JS_NO_NETWORK;
              s_d.any_net = 1'b0;
            end
          end
        end else if (scan_done_in) begin
          s_d.waiting = 1'b0;
          if (scan_in.beacon_seen && scan_in.beacon_permit && pan_ok && key_ok) begin
            s_d.pan = scan_in.beacon_pan;
            s_d.assoc_req = 1'b1;
            s_d.state = ST_ASSOC;
          end else begin
            s_d.any_net = s_q.any_net || scan_in.beacon_seen;
            s_d.idx = s_q.idx + 4'h1;
            if (s_q.idx == 4'hF) begin
              // a pass over the mask ends: record why and go again
              s_d.status = (s_q.any_net || scan_in.beacon_seen) ? JS_WRONG_ID : JS_NO_NETWORK;
              s_d.any_net = 1'b0;
            end
          end
        end
      end

      ST_ASSOC: begin
        if (assoc_done_in) begin
          if (assoc_ok_in) begin
            s_d.short_addr = assoc_addr_in;
            s_d.key = cfg_in.network_key_setting;
            s_d.disc_req = 1'b1;
            s_d.state = ST_DISCOVER;
          end else begin
            s_d.idx = s_q.idx + 4'h1;
            s_d.state = ST_JOINSCAN;
          end
        end
      end

      ST_DISCOVER: begin
        if (disc_done_in) begin
          s_d.coord_addr = disc_addr_in;
          s_d.status = JS_OK;
          s_d.nv_write = 1'b1;
          s_d.ms_valid = cfg_in.frame_mode_enable;
          s_d.ms_code = MS_JOINED;
          s_d.state = ST_ONLINE;
        end
      end

      ST_ONLINE: begin
        if (net_reset_in) begin
          s_d.children = 4'h0;
          s_d.permit_open = 1'b0;
          s_d.status = JS_SCANNING;
          s_d.state = is_coord ? ST_IDLE : ST_JOINSCAN;
          s_d.idx = 4'h0;
          s_d.waiting = 1'b0;
          s_d.any_net = 1'b0;
          if (is_coord) begin
            s_d.state = ST_ENERGY;
            s_d.best_energy = 8'hFF;
            s_d.best_idx = 4'h0;
          end
        end
      end

      default: begin
        s_d.state = ST_IDLE;
      end
    endcase

    // permit-join window opens on the cycle the node comes online
    if (s_d.state == ST_ONLINE && !online) begin
      s_d.permit_open = !is_end && (cfg_in.permit_join_time != 8'h00);
      s_d.permit_cnt = cfg_in.permit_join_time;
      s_d.sec_cnt = 32'h0;
    end else if (online && s_q.permit_open && s_q.permit_cnt != PERMIT_ALWAYS) begin
      if (s_q.sec_cnt >= 32'(SECOND_CNT - 1)) begin
        s_d.sec_cnt = 32'h0;
        s_d.permit_cnt = s_q.permit_cnt - 8'h01;
        if (s_q.permit_cnt == 8'h01) begin
          s_d.permit_open = 1'b0;
        end
      end else begin
        s_d.sec_cnt = s_q.sec_cnt + 32'h1;
      end
    end
    if (is_end) begin
      s_d.permit_open = 1'b0;
    end

    // child admission
    if (child_req_in) begin
      if (online && !is_end && s_q.permit_open && s_q.children < MAX_CHILDREN) begin
        s_d.child_accept = 1'b1;
        s_d.children = s_q.children + 4'h1;
      end else begin
        s_d.child_refuse = 1'b1;
      end
    end

    // association indicator
    s_d.online_prev = online;
    if (online != s_q.online_prev) begin
      s_d.led_cnt = 32'h0;
      s_d.led = 1'b1;
    end else if (!online) begin
      s_d.led = 1'b1;
    end else if (s_q.led_cnt >= led_limit - 32'h1) begin
      s_d.led_cnt = 32'h0;
      s_d.led = !s_q.led;
    end else begin
      s_d.led_cnt = s_q.led_cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q <= '0;
      s_q.state <= ST_IDLE;
      s_q.status <= JS_SCANNING;
      s_q.lfsr <= LFSR_SEED;
      s_q.best_energy <= 8'hFF;
      s_q.led <= 1'b1;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  // all outputs straight from the state register
  assign nv_write_out = s_q.nv_write;
  assign scan_req_out = s_q.scan_req;
  assign scan_energy_mode_out = s_q.scan_energy_mode;
  assign scan_channel_out = s_q.chan;
  assign scan_dwell_out = s_q.dwell;
  assign assoc_req_out = s_q.assoc_req;
  assign disc_req_out = s_q.disc_req;
  assign child_accept_out = s_q.child_accept;
  assign child_refuse_out = s_q.child_refuse;
  assign child_count_out = s_q.children;
  assign permit_open_out = s_q.permit_open;
  assign modem_status_valid_out = s_q.ms_valid;
  assign modem_status_code_out = s_q.ms_code;
  assign join_status_code_out = s_q.status;
  assign operating_channel_out = s_q.chan;
  assign operating_identifier_out = s_q.pan;
  assign own_short_address_out = s_q.short_addr;
  assign coord_long_address_out = s_q.coord_addr;
  assign active_key_out = s_q.key;
  assign online_out = s_q.online_prev;
  assign assoc_pin_out = s_q.led;
  assign assoc_pin_oe_out = s_q.pin_oe;

endmodule : mjc_join_ctrl

`default_nettype wire

// file: core/mjc_pkg.sv
// constants, types and state layout for the mesh network join controller
`default_nettype none

package mjc_pkg;

  localparam int CLK_HZ = 25000000;
  localparam int SECOND_MS = 1000;
  localparam int HALF_SECOND_MS = 500;
  localparam int BLINK_UNIT_MS = 10;
  localparam int SECOND_CYCLES = CLK_HZ / 1000 * SECOND_MS;
  localparam int HALF_SECOND_CYCLES = CLK_HZ / 1000 * HALF_SECOND_MS;
  localparam int BLINK_UNIT_CYCLES = CLK_HZ / 1000 * BLINK_UNIT_MS;

  localparam logic [1:0] ROLE_COORD = 2'h0;
  localparam logic [1:0] ROLE_ROUTER = 2'h1;
  localparam logic [1:0] ROLE_END = 2'h2;

  localparam logic [15:0] ANY_IDENTIFIER = 16'hFFFF;
  localparam logic [7:0] FIRST_CHANNEL = 8'h0B;
  localparam logic [7:0] PERMIT_ALWAYS = 8'hFF;
  localparam logic [3:0] MAX_CHILDREN = 4'h8;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  localparam logic [7:0] JS_OK = 8'h00;
  localparam logic [7:0] JS_WRONG_ID = 8'h22;
  localparam logic [7:0] JS_NO_NETWORK = 8'h21;
  localparam logic [7:0] JS_SCANNING = 8'hFF;
  localparam logic [7:0] MS_COORD_STARTED = 8'h01;
  localparam logic [7:0] MS_JOINED = 8'h02;

  // host-side settings, all on the module clock
  typedef struct packed {
    logic [1:0] role;
    logic [15:0] scan_channel_mask;
    logic [15:0] network_identifier_setting;
    logic [3:0] scan_duration_setting;
    logic [7:0] permit_join_time;
    logic security_enable;
    logic [127:0] network_key_setting;
    logic [7:0] encryption_options;
    logic indicator_pin_function;
    logic [7:0] blink_time_setting;
    logic frame_mode_enable;
  } mjc_cfg_t;

  // one scan result from the radio
  typedef struct packed {
    logic [7:0] energy;
    logic beacon_seen;
    logic [15:0] beacon_pan;
    logic beacon_permit;
    logic beacon_key_needed;
  } mjc_scan_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ENERGY,
    ST_NETSCAN,
    ST_JOINSCAN,
    ST_ASSOC,
    ST_DISCOVER,
    ST_ONLINE
  } mjc_state_t;

  typedef struct packed {
    mjc_state_t state;
    logic [3:0] idx;
    logic waiting;
    logic any_net;
    logic [7:0] best_energy;
    logic [3:0] best_idx;
    logic [15:0] lfsr;
    logic [7:0] chan;
    logic [15:0] pan;
    logic [15:0] short_addr;
    logic [63:0] coord_addr;
    logic [127:0] key;
    logic [7:0] status;
    logic [3:0] children;
    logic permit_open;
    logic [7:0] permit_cnt;
    logic [31:0] sec_cnt;
    logic [31:0] led_cnt;
    logic led;
    logic online_prev;
    logic scan_req;
    logic scan_energy_mode;
    logic assoc_req;
    logic disc_req;
    logic ms_valid;
    logic [7:0] ms_code;
    logic nv_write;
    logic child_accept;
    logic child_refuse;
    logic [3:0] dwell;
    logic pin_oe;
  } mjc_regs_t;

endpackage : mjc_pkg

`default_nettype wire

// file: verif/mjc_join_ctrl_asserts.sv
// concurrent checks on the join controller ports
`default_nettype none

module mjc_join_ctrl_asserts
  import mjc_pkg::*;
(
  // watched ports
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire mjc_cfg_t cfg_in,
  input wire logic child_req_in,
  input wire logic child_accept_out,
  input wire logic child_refuse_out,
  input wire logic [3:0] child_count_out,
  input wire logic modem_status_valid_out,
  input wire logic [7:0] modem_status_code_out,
  input wire logic [15:0] operating_identifier_out,
  input wire logic [15:0] own_short_address_out,
  input wire logic [127:0] active_key_out,
  input wire logic online_out,
  input wire logic assoc_pin_out,
  input wire logic assoc_done_in,
  input wire logic assoc_ok_in,
  input wire logic disc_req_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence assoc_ok_s;
    assoc_done_in && assoc_ok_in;
  endsequence
  sequence disc_ask_s;
    ##[1:2] disc_req_out;
  endsequence
  assoc_disc_a: assert property (assoc_ok_s |-> disc_ask_s)
    else $error("no discovery after admission");
  coord_addr_a: assert property (online_out && cfg_in.role == ROLE_COORD |-> own_short_address_out == 16'h0000)
    else $error("coordinator short address not zero");
  pin_high_a: assert property (cfg_in.indicator_pin_function && !online_out && !$past(online_out) |-> assoc_pin_out)
    else $error("indicator low while offline");
  end_child_a: assert property (cfg_in.role == ROLE_END |-> !child_accept_out)
    else $error("end device admitted a child");
  child_limit_a: assert property (child_req_in && child_count_out == MAX_CHILDREN |=> child_refuse_out)
    else $error("ninth child not refused");
  child_answer_a: assert property (child_req_in |=> child_accept_out != child_refuse_out)
    else $error("child request answer missing");
  status_code_a: assert property (modem_status_valid_out |->
    modem_status_code_out == ((cfg_in.role == ROLE_COORD) ? MS_COORD_STARTED : MS_JOINED))
    else $error("wrong modem status code");
  oper_ident_a: assert property (online_out && cfg_in.network_identifier_setting != ANY_IDENTIFIER |->
    operating_identifier_out == cfg_in.network_identifier_setting)
    else $error("operating identifier differs from setting");
  key_use_a: assert property (online_out && cfg_in.role == ROLE_COORD && cfg_in.security_enable |->
    active_key_out == cfg_in.network_key_setting)
    else $error("coordinator key differs from setting");
endmodule // mjc_join_ctrl_asserts

bind mjc_join_ctrl mjc_join_ctrl_asserts u_mjc_join_ctrl_asserts (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in), .cfg_in(cfg_in), .child_req_in(child_req_in),
  .child_accept_out(child_accept_out), .child_refuse_out(child_refuse_out), .child_count_out(child_count_out),
  .modem_status_valid_out(modem_status_valid_out), .modem_status_code_out(modem_status_code_out),
  .operating_identifier_out(operating_identifier_out), .own_short_address_out(own_short_address_out),
  .active_key_out(active_key_out), .online_out(online_out), .assoc_pin_out(assoc_pin_out),
  .assoc_done_in(assoc_done_in), .assoc_ok_in(assoc_ok_in), .disc_req_out(disc_req_out)
);

`default_nettype wire

// file: verif/mjc_join_ctrl_tb_top.sv
// self-checking testbench for the join controller
`default_nettype none

module mjc_join_ctrl_tb_top
  import mjc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 20;
  localparam int HALF = 10;
  localparam int UNIT = 2;
  localparam logic [127:0] KEY = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [63:0] DISC_ADDR = 64'h0123456789ABCDEF;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  mjc_cfg_t cfg_in = '0;
  logic net_reset_in = 1'b0;
  logic nv_valid_in = 1'b0;
  logic [7:0] nv_channel_in = 8'h00;
  logic [15:0] nv_pan_in = 16'h0000;
  logic child_req_in = 1'b0;
  logic slow = 1'b0;
  logic [15:0] pan = 16'h0000;
  logic nv_write_out, scan_req_out, scan_energy_mode_out, scan_done_in, assoc_req_out, assoc_done_in, assoc_ok_in;
  logic disc_req_out, disc_done_in, child_accept_out, child_refuse_out, permit_open_out, modem_status_valid_out;
  logic online_out, assoc_pin_out, assoc_pin_oe_out, nv_seen;
  logic [3:0] scan_dwell_out, child_count_out;
  logic [7:0] scan_channel_out, modem_status_code_out, join_status_code_out, operating_channel_out, scan_cnt, ms_last;
  logic [15:0] assoc_addr_in, operating_identifier_out, own_short_address_out;
  logic [63:0] disc_addr_in, coord_long_address_out;
  logic [127:0] active_key_out;
  mjc_scan_t scan_in;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;

  mjc_join_ctrl #(.SECOND_CNT(SEC), .HALF_SECOND_CNT(HALF), .BLINK_UNIT_CNT(UNIT)) u_mjc_join_ctrl (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .ce_in(1'b1), .cfg_in(cfg_in), .net_reset_in(net_reset_in),
    .nv_valid_in(nv_valid_in), .nv_channel_in(nv_channel_in), .nv_pan_in(nv_pan_in), .nv_write_out(nv_write_out),
    .scan_req_out(scan_req_out), .scan_energy_mode_out(scan_energy_mode_out), .scan_channel_out(scan_channel_out),
    .scan_dwell_out(scan_dwell_out), .scan_done_in(scan_done_in), .scan_in(scan_in), .assoc_req_out(assoc_req_out),
    .assoc_done_in(assoc_done_in), .assoc_ok_in(assoc_ok_in), .assoc_addr_in(assoc_addr_in),
    .disc_req_out(disc_req_out), .disc_done_in(disc_done_in), .disc_addr_in(disc_addr_in),
    .child_req_in(child_req_in), .child_accept_out(child_accept_out), .child_refuse_out(child_refuse_out),
    .child_count_out(child_count_out), .permit_open_out(permit_open_out),
    .modem_status_valid_out(modem_status_valid_out), .modem_status_code_out(modem_status_code_out),
    .join_status_code_out(join_status_code_out), .operating_channel_out(operating_channel_out),
    .operating_identifier_out(operating_identifier_out), .own_short_address_out(own_short_address_out),
    .coord_long_address_out(coord_long_address_out), .active_key_out(active_key_out), .online_out(online_out),
    .assoc_pin_out(assoc_pin_out), .assoc_pin_oe_out(assoc_pin_oe_out)
  );
  mjc_radio_model #(.DISC_ADDR(DISC_ADDR)) u_mjc_radio_model (
    .core_clk_in(core_clk_in), .slow_in(slow), .pan_in(pan), .scan_req_in(scan_req_out),
    .scan_energy_mode_in(scan_energy_mode_out), .scan_channel_in(scan_channel_out), .assoc_req_in(assoc_req_out),
    .disc_req_in(disc_req_out), .scan_done_out(scan_done_in), .scan_out(scan_in), .assoc_done_out(assoc_done_in),
    .assoc_ok_out(assoc_ok_in), .assoc_addr_out(assoc_addr_in), .disc_done_out(disc_done_in),
    .disc_addr_out(disc_addr_in), .scan_cnt_out(scan_cnt)
  );

  always #20 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc++;
    if (modem_status_valid_out === 1'b1) ms_last <= modem_status_code_out;
    if (nv_write_out === 1'b1) nv_seen <= 1'b1;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hw_reset(input logic [1:0] role, input logic [15:0] mask, input logic [15:0] ident, input logic [7:0] bl);
    @(posedge core_clk_in);
    resetn_in <= 1'b0;
    cfg_in <= '{role, mask, ident, 4'h3, PERMIT_ALWAYS, 1'b1, KEY, 8'h00, 1'b1, bl, 1'b1};
    ms_last <= 8'hEE;
    nv_seen <= 1'b0;
    repeat (20) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
  endtask
  task automatic tick();
    @(posedge core_clk_in);
    #1;
  endtask
  task automatic wait_online();
    for (int n = 0; n < 3000 && online_out !== 1'b1; n++) tick();
    chk(online_out, 1'b1);
  endtask
  // second interval is a full one: the first may start mid-period
  task automatic blink(input int exp);
    int n;
    logic p;
    repeat (2) begin
      p = assoc_pin_out;
      for (n = 0; n < 200 && assoc_pin_out === p; n++) tick();
    end
    chk(n, exp);
  endtask
  task automatic child(input logic acc);
    @(posedge core_clk_in);
    child_req_in <= 1'b1;
    @(posedge core_clk_in);
    child_req_in <= 1'b0;
    #1;
    chk({child_accept_out, child_refuse_out}, {acc, ~acc});
  endtask

  task automatic t_coord();
    logic [7:0] c0;
    c0 = scan_cnt;
    hw_reset(ROLE_COORD, 16'h000F, ANY_IDENTIFIER, 8'h00);
    wait_online();
    blink(SEC);
    chk(scan_cnt - c0, 8'h05);
    chk(operating_channel_out, 8'h0D);
    chk(join_status_code_out, JS_OK);
    chk(own_short_address_out, 16'h0000);
    chk(active_key_out, KEY);
    chk(ms_last, MS_COORD_STARTED);
    chk(nv_seen, 1'b1);
    chk(scan_dwell_out, 4'h3);
    chk(assoc_pin_oe_out, 1'b1);
    chk(permit_open_out, 1'b1);
    for (int i = 0; i < 9; i++) child(i < 8);
    chk(child_count_out, MAX_CHILDREN);
    $display("test coord_start done");
  endtask
  task automatic t_router();
    @(posedge core_clk_in);
    slow <= 1'b1;
    pan <= 16'h5555;
    hw_reset(ROLE_ROUTER, 16'h0001, 16'h1234, 8'h00);
    for (int n = 0; n < 500 && join_status_code_out !== JS_WRONG_ID; n++) tick();
    chk(join_status_code_out, JS_WRONG_ID);
    chk(online_out, 1'b0);
    @(posedge core_clk_in);
    pan <= 16'h1234;
    wait_online();
    blink(HALF);
    chk(operating_identifier_out, 16'h1234);
    chk(operating_channel_out, FIRST_CHANNEL);
    chk(coord_long_address_out, DISC_ADDR);
    chk(own_short_address_out, 16'h4C21);
    chk(ms_last, MS_JOINED);
    chk(join_status_code_out, JS_OK);
    $display("test router_join done");
  endtask
  task automatic t_end();
    logic [7:0] c0;
    @(posedge core_clk_in);
    slow <= 1'b0;
    pan <= 16'h5555;
    hw_reset(ROLE_END, 16'h0003, ANY_IDENTIFIER, 8'h03);
    wait_online();
    chk(operating_identifier_out, 16'h5555);
    child(1'b0);
    chk(permit_open_out, 1'b0);
    blink(3 * UNIT);
    c0 = scan_cnt;
    @(posedge core_clk_in);
    net_reset_in <= 1'b1;
    @(posedge core_clk_in);
    net_reset_in <= 1'b0;
    repeat (2) tick();
    chk(assoc_pin_out, 1'b1);
    wait_online();
    chk(scan_cnt != c0, 1'b1);
    $display("test end_device done");
  endtask
  task automatic t_retain();
    logic [7:0] c0;
    c0 = scan_cnt;
    @(posedge core_clk_in);
    {nv_valid_in, nv_channel_in, nv_pan_in} <= {1'b1, 8'h0C, 16'hBEEF};
    hw_reset(ROLE_COORD, 16'h0002, 16'hBEEF, 8'h00);
    wait_online();
    chk(scan_cnt, c0);
    chk(operating_channel_out, 8'h0C);
    chk(operating_identifier_out, 16'hBEEF);
    blink(SEC);
    $display("test retained done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    t_coord();
    t_router();
    t_end();
    t_retain();
    finish_test();
  end
endmodule // mjc_join_ctrl_tb_top

`default_nettype wire

// file: verif/mjc_radio_model.sv
// behavioural radio standing for the neighbouring nodes
`default_nettype none

module mjc_radio_model
  import mjc_pkg::*;
#(
  parameter logic [63:0] DISC_ADDR = 64'h0000000000000000
) (
  // clock and behaviour
  input wire logic core_clk_in,
  input wire logic slow_in,
  input wire logic [15:0] pan_in,
  // requests
  input wire logic scan_req_in,
  input wire logic scan_energy_mode_in,
  input wire logic [7:0] scan_channel_in,
  input wire logic assoc_req_in,
  input wire logic disc_req_in,
  // answers
  output logic scan_done_out,
  output mjc_scan_t scan_out,
  output logic assoc_done_out,
  output logic assoc_ok_out,
  output logic [15:0] assoc_addr_out,
  output logic disc_done_out,
  output logic [63:0] disc_addr_out,
  output logic [7:0] scan_cnt_out
);
  logic [3:0] wait_q = 4'h0;
  logic [1:0] kind_q = 2'h0;
  logic mode_q = 1'b0;
  logic [7:0] chan_q = 8'h00;
  initial begin
    {scan_done_out, assoc_done_out, disc_done_out, assoc_ok_out} = 4'h0;
    {scan_out, assoc_addr_out, disc_addr_out, scan_cnt_out} = '0;
  end
  always @(posedge core_clk_in) begin
    {scan_done_out, assoc_done_out, disc_done_out} <= 3'h0;
    // idle answer lines change every cycle so a stale value is never trusted
    scan_out <= ~scan_out;
    assoc_ok_out <= ~assoc_ok_out;
    assoc_addr_out <= ~assoc_addr_out;
    disc_addr_out <= ~disc_addr_out;
    if (scan_req_in || assoc_req_in || disc_req_in) begin
      wait_q <= slow_in ? 4'h6 : 4'h1;
      kind_q <= scan_req_in ? 2'h0 : (assoc_req_in ? 2'h1 : 2'h2);
      mode_q <= scan_energy_mode_in;
      chan_q <= scan_channel_in;
      scan_cnt_out <= scan_cnt_out + {7'h00, scan_req_in};
    end else if (wait_q == 4'h1) begin
      wait_q <= 4'h0;
      if (kind_q == 2'h0) begin
        scan_done_out <= 1'b1;
        scan_out <= '{(chan_q == 8'h0D) ? 8'h05 : 8'h30, !mode_q, pan_in, 1'b1, 1'b0};
      end else if (kind_q == 2'h1) begin
        assoc_done_out <= 1'b1;
        assoc_ok_out <= 1'b1;
        assoc_addr_out <= 16'h4C21;
      end else begin
        disc_done_out <= 1'b1;
        disc_addr_out <= DISC_ADDR;
      end
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end
  end
endmodule // mjc_radio_model

`default_nettype wire
